// File: src/pcicks_top.sv
/*
  Bus clock source and outputs: primary clock choice, divide-by-two stage,
  sync output mux and three gated bus clock outputs, with an AXI4-Lite
  register slave.
  // Operation
  // - Primary clock from one of two inputs
  // - Host select bit 1 means host mode
  // - Host mode: reference feeds divider and muxes
  // - Strap picks reference or half for sync
  // - Three bus clock outputs in host mode
  // - Outputs held low after reset
  // - Each output toggles only when enabled
  // - Enabled outputs stay phase-aligned
  // - Agent mode: outputs and sync unused
  Assumes the reference clock arrives as a slower pin level, sampled on aclk;
  the generated clocks are therefore aclk-rate approximations.
*/
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pcicks_consts.svh"

module pcicks_top
  import pcicks_pkg::*;
(
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // Pins and straps
  input  wire logic                      host_reference_clock_in,
  input  wire logic                      bus_clock_in,
  input  wire logic                      host_mode_select,
  input  wire logic                      reference_divide_strap,
  // Clock outputs
  output logic                           sync_out,
  output logic [`PCICKS_N_OUT-1:0]       bus_clock_out,
  output logic                           primary_clock,
  // AXI4-Lite write
  input  wire logic [`PCICKS_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // AXI4-Lite read
  input  wire logic [`PCICKS_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready
);

  // Pin synchronisers: first stage feeds only the second.
  // They run through reset so the straps are settled when caught;
  // clearing them would make the catch see zeros and force agent mode.
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  always_ff @(posedge aclk) begin
    sync1_r <= {reference_divide_strap, host_mode_select,
                bus_clock_in, host_reference_clock_in};
    sync2_r <= sync1_r;
  end
  wire ref_s  = sync2_r[0];
  wire bclk_s = sync2_r[1];

  // Straps are caught once, the cycle after reset releases
  pcicks_straps_s straps_r;
  logic           caught_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      straps_r <= '0;
      caught_r <= 1'b0;
    end else if (!caught_r) begin
      straps_r <= '{host_mode: sync2_r[2], div_strap: sync2_r[3]};
      caught_r <= 1'b1;
    end
  end
  wire host = straps_r.host_mode;

  // Primary clock: exactly one source
  assign primary_clock = host ? ref_s : bclk_s;

  // Divide-by-two on rising edges of the reference
  logic ref_d_r;
  logic half_r;
  wire  ref_rise = ref_s & ~ref_d_r;
  wire  half_nxt = (host && ref_rise) ? ~half_r : half_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_d_r <= 1'b0;
      half_r  <= 1'b0;
    end else begin
      ref_d_r <= ref_s;
      half_r  <= half_nxt;
    end
  end

  // Mux feeding sync and bus outputs; agent mode parks both low
  wire  div_sel   = straps_r.div_strap;
  wire  phase     = host & (div_sel ? half_r : ref_d_r);
  wire  phase_nxt = host & (div_sel ? half_nxt : ref_s);
  logic sync_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) sync_r <= 1'b0;
    else          sync_r <= phase_nxt;
  end
  assign sync_out = sync_r;

  // Output clock control register
  localparam logic [31:0] ctrl_rst_word = `PCICKS_CTRL_RST;
  logic [`PCICKS_N_OUT-1:0] ctrl_r;
  logic [`PCICKS_N_OUT-1:0] en_act;

  genvar g;
  generate
    for (g = 0; g < `PCICKS_N_OUT; g++) begin : g_out
      pcicks_out_gate u_gate (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .en_req    (ctrl_r[g] & host),
        .phase     (phase),
        .phase_nxt (phase_nxt),
        .clk_out   (bus_clock_out[g]),
        .en_act    (en_act[g])
      );
    end
  endgenerate

  // Write channel: address and data taken in either order
  logic                      aw_got_r;
  logic                      w_got_r;
  logic [`PCICKS_ADDR_W-1:0] awaddr_r;
  logic [31:0]               wdata_r;
  logic [3:0]                wstrb_r;
  logic                      bvalid_r;
  logic [1:0]                bresp_r;

  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready  = !w_got_r && !bvalid_r;
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire  = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_got_r || aw_fire;
  wire w_have  = w_got_r || w_fire;
  wire [`PCICKS_ADDR_W-1:0] wa = aw_got_r ? awaddr_r : s_axi_awaddr;
  wire [31:0]               wd = w_got_r ? wdata_r : s_axi_wdata;
  wire [3:0]                ws = w_got_r ? wstrb_r : s_axi_wstrb;
  wire do_write = aw_have && w_have && !bvalid_r;

  function automatic logic is_mapped(input logic [`PCICKS_ADDR_W-1:0] a);
    is_mapped = (a == `PCICKS_OFF_CTRL) || (a == `PCICKS_OFF_STATUS) ||
                (a == `PCICKS_OFF_MODE);
  endfunction : is_mapped

  wire ctrl_wr = do_write && (wa == `PCICKS_OFF_CTRL) && ws[0];
  wire [`PCICKS_N_OUT-1:0] ctrl_nxt = ctrl_wr ?
    wd[`PCICKS_EN_LSB +: `PCICKS_N_OUT] : ctrl_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= '0;
      wdata_r  <= '0;
      wstrb_r  <= '0;
      bvalid_r <= 1'b0;
      bresp_r  <= `PCICKS_RESP_OKAY;
      ctrl_r   <= ctrl_rst_word[`PCICKS_EN_LSB +: `PCICKS_N_OUT];
    end else begin
      ctrl_r <= ctrl_nxt;
      if (aw_fire) awaddr_r <= s_axi_awaddr;
      if (w_fire) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= is_mapped(wa) ? `PCICKS_RESP_OKAY : `PCICKS_RESP_SLVERR;
      end else begin
        aw_got_r <= aw_have;
        w_got_r  <= w_have;
        if (bvalid_r && s_axi_bready) bvalid_r <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // Read channel: one outstanding read, answer one cycle after address
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  assign s_axi_arready = !rvalid_r;
  wire ar_fire = s_axi_arvalid && s_axi_arready;

  wire [31:0] status_word =
    (32'(en_act) << `PCICKS_ST_EN_LSB) |
    (32'(host) << `PCICKS_ST_HOST_BIT) |
    (32'(div_sel) << `PCICKS_ST_DIV_BIT) |
    (32'(phase) << `PCICKS_ST_PH_BIT);
  wire [31:0] mode_word =
    (32'(host) << `PCICKS_MODE_HOST_BIT) | (32'(div_sel) << `PCICKS_MODE_DIV_BIT);
  wire [31:0] rd_mux =
    (s_axi_araddr == `PCICKS_OFF_CTRL)   ? (32'(ctrl_r) << `PCICKS_EN_LSB) :
    (s_axi_araddr == `PCICKS_OFF_STATUS) ? status_word :
    (s_axi_araddr == `PCICKS_OFF_MODE)   ? mode_word : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `PCICKS_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= is_mapped(s_axi_araddr) ? `PCICKS_RESP_OKAY : `PCICKS_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

endmodule : pcicks_top

`default_nettype wire

// File: src/pcicks_consts.svh
/*
  Constants of the bus clock source block: register offsets, field positions,
  reset values and response codes.
  Assumes inclusion by its bare name from the package and the top module.
*/
`ifndef PCICKS_CONSTS_SVH
`define PCICKS_CONSTS_SVH

`define PCICKS_N_OUT         3
`define PCICKS_ADDR_W        4
`define PCICKS_OFF_CTRL      4'h0
`define PCICKS_OFF_STATUS    4'h4
`define PCICKS_OFF_MODE      4'h8
`define PCICKS_CTRL_RST      32'h0000_0000
`define PCICKS_EN_LSB        0
`define PCICKS_ST_EN_LSB     0
`define PCICKS_ST_HOST_BIT   3
`define PCICKS_ST_DIV_BIT    4
`define PCICKS_ST_PH_BIT     5
`define PCICKS_MODE_HOST_BIT 0
`define PCICKS_MODE_DIV_BIT  1
`define PCICKS_RESP_OKAY     2'h0
`define PCICKS_RESP_SLVERR   2'h2

`endif

// File: src/pcicks_pkg.sv
/*
  Types shared by the bus clock source block.
  Assumes the constants header is on the include path.
*/
`include "pcicks_consts.svh"

package pcicks_pkg;

  typedef logic [`PCICKS_N_OUT-1:0] pcicks_en_t;

  // Strap values caught after reset release
  typedef struct packed {
    logic host_mode;
    logic div_strap;
  } pcicks_straps_s;

  typedef enum logic [1:0] {
    PCICKS_W_IDLE = 2'b00,
    PCICKS_W_RESP = 2'b01
  } pcicks_wst_e;

endpackage : pcicks_pkg

// File: src/pcicks_out_gate.sv
/*
  One gated bus clock output. Enable changes are taken only while the
  selected clock is low, so no runt pulse reaches the pin.
  Assumes the clock phase and its next value come from one shared
  divider so that all outputs stay aligned.
*/
`timescale 1ns/1ps
`default_nettype none

module pcicks_out_gate (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control
  input  wire logic en_req,
  input  wire logic phase,
  input  wire logic phase_nxt,
  // Output
  output logic      clk_out,
  output logic      en_act
);

  logic en_r;
  logic out_r;
  wire  en_nxt  = (!phase && !phase_nxt) ? en_req : en_r;
  wire  out_nxt = en_nxt & phase_nxt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_r  <= 1'b0;
      out_r <= 1'b0;
    end else begin
      en_r  <= en_nxt;
      out_r <= out_nxt;
    end
  end

  assign clk_out = out_r;
  assign en_act  = en_r;

endmodule : pcicks_out_gate

`default_nettype wire

// File: verif/pcicks_asserts.sv
/* Checker of the bus clock source block, bound to its top module.
   Assumes straps change only while reset is held. */
`timescale 1ns/1ps
`default_nettype none
module pcicks_asserts
  import pcicks_pkg::*;
(
  // Clock, reset and pins
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       host_reference_clock_in,
  input wire logic       bus_clock_in,
  input wire logic       host_mode_select,
  input wire logic       reference_divide_strap,
  // Clock outputs
  input wire logic       sync_out,
  input wire logic [2:0] bus_clock_out,
  input wire logic       primary_clock,
  // Register writes
  input wire logic [3:0] s_axi_awaddr,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready
);
  logic [2:0] up_r;
  logic [2:0] seen_r;
  wire        src = host_mode_select ? host_reference_clock_in : bus_clock_in;
  // Enables ever written since reset: outputs may lag them, never lead
  wire        ctrl_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
                        s_axi_awaddr == 4'h0 && s_axi_wstrb[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_r   <= 3'h0;
      seen_r <= 3'h0;
    end else begin
      up_r   <= (up_r == 3'h7) ? up_r : up_r + 3'h1;
      seen_r <= ctrl_wr ? (seen_r | s_axi_wdata[2:0]) : seen_r;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst_low;
    disable iff (1'b0) !aresetn |=> bus_clock_out == 3'h0 && sync_out == 1'b0;
  endproperty
  a_rst_low: assert property (p_rst_low) else $error("clock out high in reset");
  property p_rise_al;
    (bus_clock_out & ~$past(bus_clock_out)) != 3'h0 |-> $rose(sync_out);
  endproperty
  a_rise_al: assert property (p_rise_al) else $error("rise off sync edge");
  property p_fall_al;
    (~bus_clock_out & $past(bus_clock_out)) != 3'h0 |-> $fell(sync_out);
  endproperty
  a_fall_al: assert property (p_fall_al) else $error("fall off sync edge");
  property p_agent;
    !host_mode_select && up_r > 3'h1 |-> sync_out == 1'b0 && bus_clock_out == 3'h0;
  endproperty
  a_agent: assert property (p_agent) else $error("clock out in agent mode");
  property p_prim;
    up_r == 3'h7 |-> primary_clock == $past(src, 2) || primary_clock == $past(src, 3);
  endproperty
  a_prim: assert property (p_prim) else $error("wrong primary clock");
  property p_direct;
    host_mode_select && !reference_divide_strap && up_r == 3'h7 &&
      $rose(host_reference_clock_in) |-> ##[1:5] $rose(sync_out);
  endproperty
  a_direct: assert property (p_direct) else $error("sync not following ref");
  property p_half;
    host_mode_select && reference_divide_strap && up_r == 3'h7 &&
      $rose(host_reference_clock_in) |-> ##[1:5] $changed(sync_out);
  endproperty
  a_half: assert property (p_half) else $error("half clock not toggling");
  property p_seen;
    (bus_clock_out & ~seen_r) == 3'h0;
  endproperty
  a_seen: assert property (p_seen) else $error("output never enabled");
  c_all_on: cover property (bus_clock_out == 3'h7);
  c_write: cover property (ctrl_wr);
  c_agent: cover property (!host_mode_select && up_r == 3'h7);
endmodule : pcicks_asserts

bind pcicks_top pcicks_asserts i_pcicks_asserts (.*);
`default_nettype wire

// File: verif/pcicks_agents.sv
/* Agent-side model: counts rising edges of the three bus clocks and
   the looped-back sync clock. Assumes clocks far slower than aclk. */
`timescale 1ns/1ps
`default_nettype none
module pcicks_agents (
  // Sampling clock and clear
  input  wire logic            aclk,
  input  wire logic            clr,
  // Received clocks, sync in bit 3
  input  wire logic [3:0]      clk_in,
  // Rising edges since clear
  output logic      [3:0][7:0] cnt
);
  logic [3:0] prev_r;
  always_ff @(posedge aclk) begin
    prev_r <= clk_in;
    for (int i = 0; i < 4; i++) begin
      if (clr) begin
        cnt[i] <= 8'h00;
      end else if (clk_in[i] && !prev_r[i]) begin
        cnt[i] <= cnt[i] + 8'h01;
      end
    end
  end
endmodule : pcicks_agents
`default_nettype wire

// File: verif/pci_clock_source_and_outputs_tb.sv
/* Bench of the bus clock source: strap modes, gated outputs, register bus.
   Assumes the checker binds itself to the top module. */
`timescale 1ns/1ps
`default_nettype none
module pci_clock_source_and_outputs_tb
  import pcicks_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, host_reference_clock_in = 1'b0, bus_clock_in = 1'b0;
  logic host_mode_select = 1'b1, reference_divide_strap = 1'b1, clr = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sync_out, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd = 32'hcc86;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] bus_clock_out, rc = 3'h0;
  logic [3:0][7:0] cnt;
  int mismatches = 0, n_tests = 0, cyc = 0;
  pcicks_top i_pcicks_top (.*, .primary_clock());
  pcicks_agents i_pcicks_agents (.aclk, .clr, .clk_in({sync_out, bus_clock_out}), .cnt);
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // Rising edges in a 128-cycle window; the reference period is 8 cycles
  function automatic logic [7:0] exp_cnt(input logic h, input logic d, input logic e);
    return (h && e) ? (d ? 8'h08 : 8'h10) : 8'h00;
  endfunction : exp_cnt
  task automatic complete_run();
    if (mismatches == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic do_reset(input logic h, input logic d);
    @(posedge aclk);
    aresetn <= 1'b0;
    host_mode_select <= h;
    reference_divide_strap <= d;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset
  // One write or one read; d is write data or expected read data
  task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [31:0] m, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid || s_axi_rvalid) begin
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (!wr) chk(s_axi_rdata & m, d & m);
        chk({30'h0, wr ? s_axi_bresp : s_axi_rresp}, {30'h0, er});
        return;
      end
    end
  endtask : axi
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    rc <= rc + 3'h1;
    host_reference_clock_in <= rc[2];
    rnd <= lfsr(rnd);
    bus_clock_in <= rnd[7];
    cyc <= cyc + 1;
    // The whole run needs about 2200 cycles
    if (cyc == 6000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    logic       h;
    logic       d;
    logic [2:0] m;
    for (int k = 0; k < 3; k++) begin
      h = (k != 2);
      d = (k != 1);
      do_reset(h, d);
      axi(1'b0, 4'h8, {30'h0, d, h}, 4'h0, 32'hffff_ffff, 2'h0);
      axi(1'b0, 4'h0, 32'h0, 4'h0, 32'hffff_ffff, 2'h0);
      axi(1'b1, 4'hc, 32'h7, 4'hf, 32'h0, 2'h2);
      axi(1'b0, 4'hc, 32'h0, 4'h0, 32'hffff_ffff, 2'h2);
      // Lane 0 strobe off, so the enables must stay clear
      axi(1'b1, 4'h0, 32'h7, 4'h0, 32'h0, 2'h0);
      for (int j = 0; j < 4; j++) begin
        m = (j == 0) ? 3'h0 : (j == 3) ? 3'h7 : rnd[2:0];
        if (j > 0) axi(1'b1, 4'h0, {29'h0, m}, 4'hf, 32'h0, 2'h0);
        if (j > 0) axi(1'b0, 4'h0, {29'h0, m}, 4'h0, 32'hffff_ffff, 2'h0);
        repeat (40) @(posedge aclk);
        // Agent mode ignores the enables, so none may show as applied
        axi(1'b0, 4'h4, {27'h0, d, h, h ? m : 3'h0}, 4'h0, 32'h1f, 2'h0);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        repeat (129) @(posedge aclk);
        for (int i = 0; i < 4; i++) begin
          chk({24'h0, cnt[i]}, {24'h0, exp_cnt(h, d, i == 3 || m[i])});
        end
      end
    end
    complete_run();
  end
endmodule : pci_clock_source_and_outputs_tb
`default_nettype wire
